// ---- ldp_i2c_front.sv ----
// Function
// - Address pins form low regular address bits
// - Address LSB one reads, zero writes
// - Broadcast address E0h enabled, rewritable
// - Three group addresses default ECh, rewritable
// - Only first group address enabled at reset
// - First written byte loads the pointer
// - Pointer low seven select, top bit increments
// - Increment flag set after reset
// - Mode bits from config bits 5, 6
// - Flag set steps index per data byte
// - Flag clear holds index fixed
// - Mode 00 wraps 41h to 00h
// - Mode 01 wraps 19h to 0Ah
// - Mode 10 wraps 31h to 00h
// - Mode 11 wraps 19h to 08h
// - Increment leaves flag bit untouched
// - Written index selects first accessed register
// - Index below window counts up, then wraps
// - Writes to unused registers get NACK
module ldp_i2c_front
  import ldp_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [3:0] addr_pins_i,
  input wire logic [2:0] regular_high_i,
  output logic [7:0] pointer_o,
  output logic busy_o
);
  typedef enum logic [2:0] {
    LDP_IDLE, LDP_ADDR, LDP_AACK, LDP_WBYTE, LDP_WACK, LDP_RBYTE, LDP_RACK
  } ldp_state_e;

  // SDA is sampled once on each rising SCL edge; start and stop seen on SDA edges.
  ldp_state_e state_r;
  logic [7:0] shift_r;
  logic [3:0] bits_r;
  logic first_r;
  logic ack_r;
  logic rd_r;
  logic [7:0] cfg_r;
  logic [6:0] bcast_r;
  logic [6:0] grp_r [3];
  logic [2:0] grp_en_r;
  logic bcast_en_r;
  logic start_t_r;
  logic stop_t_r;
  logic [6:0] pins_meta_r;
  logic [6:0] pins_sync_r;
  wire [2:0] grp_hit;
  logic active_r;
  logic [6:0] regular;
  logic addr_hit;
  logic [7:0] rx_byte;
  logic unused_idx;
  logic [6:0] widx;
  logic [7:0] rdata;
  ldp_ptr_if pb ();

  ldp_ptr u_ptr (
    .scl_i(scl_i),
    .rst_n_i(reset_n_i),
    .pb(pb)
  );

  // Address straps are pins; two link clocks pass long before the
  // address byte has been shifted in, so the extra latency is free.
  always_ff @(posedge scl_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pins_meta_r <= 7'h00;
      pins_sync_r <= 7'h00;
    end else begin
      pins_meta_r <= {regular_high_i, addr_pins_i};
      pins_sync_r <= pins_meta_r;
    end
  end

  assign regular = pins_sync_r;
  assign rx_byte = {shift_r[6:0], sda_i};
  assign widx = pb.ptr[6:0];
  assign pb.mode = {cfg_r[MODE_HI_BIT], cfg_r[MODE_LO_BIT]};
  assign pb.wdata = rx_byte;

  always_comb begin
    addr_hit = (rx_byte[7:1] == regular);
    if (bcast_en_r && rx_byte[7:1] == bcast_r) begin
      addr_hit = 1'b1;
    end
    if (|grp_hit) begin
      addr_hit = 1'b1;
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_grp_hit
    assign grp_hit[g] = grp_en_r[g]
      && (rx_byte[7:1] == grp_r[g]);
  end

  always_comb begin
    unused_idx = 1'b0;
    if (widx == 7'h06 || widx == 7'h07) begin
      unused_idx = 1'b1;
    end else if (widx >= 7'h1A && widx <= 7'h21) begin
      unused_idx = 1'b1;
    end else if (widx >= 7'h32 && widx <= 7'h39) begin
      unused_idx = 1'b1;
    end else if (widx > IDX_LAST) begin
      unused_idx = 1'b1;
    end
  end

  always_comb begin
    rdata = 8'h00;
    if (widx == IDX_CFG) begin
      rdata = cfg_r;
    end else if (widx == IDX_BCAST) begin
      rdata = {bcast_r, 1'b0};
    end else if (widx == IDX_GRP1) begin
      rdata = {grp_r[0], 1'b0};
    end else if (widx == IDX_GRP2) begin
      rdata = {grp_r[1], 1'b0};
    end else if (widx == IDX_GRP3) begin
      rdata = {grp_r[2], 1'b0};
    end else if (widx == IDX_ENABLES) begin
      rdata = {4'h0, grp_en_r, bcast_en_r};
    end
  end

  // Start and stop are sampled asynchronously to SCL by SDA edges.
  always_ff @(negedge sda_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      start_t_r <= 1'b0;
    end else if (scl_i) begin
      start_t_r <= ~start_t_r;
    end
  end

  always_ff @(posedge sda_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stop_t_r <= 1'b0;
    end else if (scl_i) begin
      stop_t_r <= ~stop_t_r;
    end
  end

  logic start_seen_nxt;
  logic stop_prev_r;
  logic start_prev_r;
  assign start_seen_nxt = (start_t_r != start_prev_r);

  always_ff @(posedge scl_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      start_prev_r <= 1'b0;
      stop_prev_r <= 1'b0;
    end else begin
      start_prev_r <= start_t_r;
      stop_prev_r <= stop_t_r;
    end
  end

  assign pb.load = (state_r == LDP_WBYTE) && (bits_r == 4'h7) && first_r
    && !start_seen_nxt;
  // A read byte counts as accessed once its last bit has gone out, so the
  // pointer steps even when the master refuses it, and a following byte
  // is fetched from the stepped index.
  assign pb.step = !start_seen_nxt && (bits_r == 4'h7)
    && (((state_r == LDP_WBYTE) && !first_r)
    || (state_r == LDP_RBYTE));

  always_ff @(posedge scl_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= LDP_IDLE;
      shift_r <= 8'h00;
      bits_r <= 4'h0;
      first_r <= 1'b0;
      ack_r <= 1'b0;
      rd_r <= 1'b0;
    end else if (start_seen_nxt) begin
      state_r <= LDP_ADDR;
      shift_r <= {7'h00, sda_i};
      bits_r <= 4'h1;
    end else begin
      case (state_r)
        LDP_ADDR: begin
          shift_r <= rx_byte;
          bits_r <= bits_r + 4'h1;
          if (bits_r == 4'h7) begin
            ack_r <= addr_hit;
            rd_r <= rx_byte[0];
            first_r <= ~rx_byte[0];
            state_r <= addr_hit ? LDP_AACK : LDP_IDLE;
          end
        end
        LDP_AACK: begin
          bits_r <= 4'h0;
          state_r <= rd_r ? LDP_RBYTE : LDP_WBYTE;
          shift_r <= rdata;
        end
        LDP_WBYTE: begin
          shift_r <= rx_byte;
          bits_r <= bits_r + 4'h1;
          if (bits_r == 4'h7) begin
            ack_r <= first_r || !unused_idx;
            first_r <= 1'b0;
            state_r <= LDP_WACK;
          end
        end
        LDP_WACK: begin
          bits_r <= 4'h0;
          state_r <= LDP_WBYTE;
        end
        LDP_RBYTE: begin
          shift_r <= {shift_r[6:0], 1'b0};
          bits_r <= bits_r + 4'h1;
          if (bits_r == 4'h7) begin
            state_r <= LDP_RACK;
          end
        end
        LDP_RACK: begin
          bits_r <= 4'h0;
          shift_r <= rdata;
          state_r <= sda_i ? LDP_IDLE : LDP_RBYTE;
        end
        default: begin
          // Idle ignores every clock, stop clocks too, until a start.
          bits_r <= 4'h0;
        end
      endcase
    end
  end

  // Configuration and address registers written with the data byte.
  always_ff @(posedge scl_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_r <= CFG_RESET;
      bcast_r <= BCAST_RESET;
      grp_r <= '{GROUP_RESET, GROUP_RESET, GROUP_RESET};
      grp_en_r <= GROUP_EN_RESET;
      bcast_en_r <= 1'b1;
    end else if (pb.step && state_r == LDP_WBYTE) begin
      if (widx == IDX_CFG) begin
        cfg_r <= rx_byte;
      end else if (widx == IDX_BCAST) begin
        bcast_r <= rx_byte[7:1];
      end else if (widx == IDX_GRP1) begin
        grp_r[0] <= rx_byte[7:1];
      end else if (widx == IDX_GRP2) begin
        grp_r[1] <= rx_byte[7:1];
      end else if (widx == IDX_GRP3) begin
        grp_r[2] <= rx_byte[7:1];
      end else if (widx == IDX_ENABLES) begin
        grp_en_r <= rx_byte[3:1];
        bcast_en_r <= rx_byte[0];
      end
    end
  end

  // Output changes on falling SCL so data is stable while SCL is high.
  always_ff @(negedge scl_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sda_oe_o <= 1'b0;
    end else begin
      sda_oe_o <= ((state_r == LDP_AACK || state_r == LDP_WACK) && ack_r)
        || (state_r == LDP_RBYTE && !shift_r[7]);
    end
  end

  // A stop shows as the stop toggle running ahead of its copy, which only
  // catches up at the next link clock, so busy drops with no clock.
  logic busy_link;
  always_ff @(posedge scl_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      active_r <= 1'b0;
    end else if (start_seen_nxt) begin
      active_r <= 1'b1;
    end else if (state_r == LDP_ADDR && bits_r == 4'h7 && !addr_hit) begin
      active_r <= 1'b0;
    end
  end

  assign busy_link = active_r && (stop_t_r == stop_prev_r);

  logic busy_meta_r;
  logic busy_r;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_meta_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      busy_meta_r <= busy_link;
      busy_r <= busy_meta_r;
    end
  end

  assign sda_o = 1'b0;
  assign pointer_o = pb.ptr;
  assign busy_o = busy_r;

  a_addr_ack: assert property (@(posedge scl_i)
    disable iff (!reset_n_i)
    state_r == LDP_ADDR && bits_r == 4'h7 && addr_hit && !start_seen_nxt
    |=> state_r == LDP_AACK) else $error("address not acked");
  a_unused_nack: assert property (@(posedge scl_i)
    disable iff (!reset_n_i)
    state_r == LDP_WBYTE && bits_r == 4'h7 && !first_r && unused_idx
    && !start_seen_nxt |=> !ack_r) else $error("unused reg acked");
  a_ptr_load: assert property (@(posedge scl_i)
    disable iff (!reset_n_i)
    pb.load |=> pb.ptr == $past(rx_byte)) else $error("pointer not loaded");
  c_write: cover property (@(posedge scl_i) disable iff (!reset_n_i)
    state_r == LDP_WACK && ack_r);
  c_read: cover property (@(posedge scl_i) disable iff (!reset_n_i)
    state_r == LDP_RACK);
endmodule // ldp_i2c_front

// ---- ldp_i2c_front_tb_top.sv ----
module ldp_i2c_front_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, reset_n_i, scl, m_oe, sda_o, sda_oe_o, busy_o;
  logic [3:0] pins;
  logic [2:0] high;
  logic [7:0] pointer_o;
  // Open drain with a pull-up: either party pulling wins.
  wire sda = !(m_oe || (sda_oe_o && !sda_o));
  int err_total = 0;
  int cmp_count = 0;
  logic [7:0] last [4] = '{8'hC1, 8'h99, 8'hB1, 8'h99};
  logic [7:0] wrap [4] = '{8'h80, 8'h8A, 8'h80, 8'h88};

  ldp_i2c_front ldp_i2c_front_inst (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .addr_pins_i(pins),
    .regular_high_i(high),
    .pointer_o(pointer_o),
    .busy_o(busy_o)
  );

  ldp_i2c_master ldp_i2c_master_inst (
    .scl_o(scl),
    .sda_oe_o(m_oe),
    .sda_i(sda)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // The acknowledge is checked 8 ns after the acknowledge clock has fallen.
  task automatic put(input logic [7:0] b, input logic exp);
    logic ack;
    ldp_i2c_master_inst.send(b, ack);
    #8;
    check({7'h00, ack}, {7'h00, exp});
  endtask

  task automatic adr(input logic [7:0] a, input logic exp);
    ldp_i2c_master_inst.start();
    put(a, exp);
  endtask

  task automatic fin();
    ldp_i2c_master_inst.stop();
  endtask

  // Written with the flag set, so no reserved combination is ever seen.
  task automatic wcfg(input logic [1:0] m);
    adr(8'hAA, 1'b1);
    put(8'h80, 1'b1);
    put({1'b0, m, 5'h00}, 1'b1);
    fin();
  endtask

  task automatic t_address();
    logic [7:0] d;
    adr(8'hAA, 1'b1);
    check({7'h00, busy_o}, 8'h01);
    fin();
    repeat (4) @(negedge clk_i);
    check({7'h00, busy_o}, 8'h00);
    adr(8'hA8, 1'b0);
    check({7'h00, busy_o}, 8'h00);
    fin();
    @(negedge clk_i);
    pins = 4'hA;
    adr(8'hB4, 1'b1);
    fin();
    @(negedge clk_i);
    pins = 4'h5;
    adr(8'hE0, 1'b1);
    put(8'h9A, 1'b1);
    check(pointer_o, 8'h9A);
    put(8'h11, 1'b0);
    check(pointer_o, 8'h9B);
    fin();
    adr(8'hE1, 1'b1);
    ldp_i2c_master_inst.recv(d);
    #8;
    check(pointer_o, 8'h9C);
    fin();
    adr(8'hEC, 1'b1);
    fin();
  endtask

  task automatic t_groups();
    logic [7:0] d;
    adr(8'hAA, 1'b1);
    put(8'h3C, 1'b1);
    put(8'hD0, 1'b1);
    fin();
    adr(8'hAA, 1'b1);
    put(8'h3C, 1'b1);
    adr(8'hAB, 1'b1);
    ldp_i2c_master_inst.recv(d);
    check(d, 8'hD0);
    fin();
    adr(8'hAA, 1'b1);
    put(8'h3F, 1'b1);
    put(8'h04, 1'b1);
    fin();
    adr(8'hD0, 1'b1);
    fin();
    adr(8'hEC, 1'b0);
    fin();
    adr(8'hE0, 1'b0);
    fin();
  endtask

  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      wcfg(i[1:0]);
      adr(8'hAA, 1'b1);
      put(last[i], 1'b1);
      put(8'h11, 1'b1);
      check(pointer_o, wrap[i]);
      fin();
    end
  endtask

  task automatic t_below();
    wcfg(2'h1);
    adr(8'hAA, 1'b1);
    put(8'h88, 1'b1);
    for (int i = 0; i < 18; i++) put(8'h22, 1'b1);
    check(pointer_o, 8'h8A);
    fin();
  endtask

  task automatic t_fixed();
    wcfg(2'h0);
    adr(8'hAA, 1'b1);
    put(8'h05, 1'b1);
    for (int i = 0; i < 3; i++) put(8'h33, 1'b1);
    check(pointer_o, 8'h05);
    fin();
    adr(8'hAA, 1'b1);
    put(8'h06, 1'b1);
    put(8'h44, 1'b0);
    fin();
  endtask

  initial begin
    for (int i = 0; i < 90000; i++) @(posedge clk_i);
    err_total++;
    results();
  end

  initial begin
    reset_n_i = 1'b0;
    pins = 4'h5;
    high = 3'h5;
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    check(pointer_o, 8'h80);
    check({7'h00, sda_oe_o}, 8'h00);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_address();
    t_modes();
    t_below();
    t_fixed();
    t_groups();
    results();
  end
endmodule // ldp_i2c_front_tb_top

// ---- ldp_i2c_master.sv ----
module ldp_i2c_master (
  output logic scl_o,
  output logic sda_oe_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quarter of the 64 ns link period; raise it to model a slow master.
  parameter int Q = 16;

  // The clock stands high between frames, as the bus idles there.
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // Data moves only while the clock is low; sampled mid-high.
  task automatic bit_cyc(input logic b, output logic seen);
    #Q sda_oe_o = ~b;
    #Q scl_o = 1'b1;
    #Q seen = sda_i;
    #Q scl_o = 1'b0;
  endtask

  task automatic start();
    #Q sda_oe_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_oe_o = 1'b1;
    #Q scl_o = 1'b0;
  endtask

  task automatic stop();
    #Q sda_oe_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_oe_o = 1'b0;
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(b[i], s);
    bit_cyc(1'b1, s);
    ack = ~s;
  endtask

  // Every byte read is refused, so the target lets go of the line.
  task automatic recv(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b1, s);
      d[i] = s;
    end
    bit_cyc(1'b1, s);
  endtask
endmodule // ldp_i2c_master

// ---- ldp_pkg.sv ----
package ldp_pkg;
  localparam logic [6:0] BCAST_RESET = 7'h70;
  localparam logic [6:0] GROUP_RESET = 7'h76;
  localparam logic [6:0] IDX_LAST = 7'h41;
  localparam logic [6:0] IDX_ZERO = 7'h00;
  localparam logic [6:0] IDX_PWM_FIRST = 7'h0A;
  localparam logic [6:0] IDX_GRP_FIRST = 7'h08;
  localparam logic [6:0] IDX_PWM_LAST = 7'h19;
  localparam logic [6:0] IDX_GAIN_LAST = 7'h31;
  localparam logic [6:0] IDX_CFG = 7'h00;
  localparam logic [6:0] IDX_BCAST = 7'h3E;
  localparam logic [6:0] IDX_GRP1 = 7'h3B;
  localparam logic [6:0] IDX_GRP2 = 7'h3C;
  localparam logic [6:0] IDX_GRP3 = 7'h3D;
  localparam logic [6:0] IDX_ENABLES = 7'h3F;
  localparam int MODE_HI_BIT = 6;
  localparam int MODE_LO_BIT = 5;
  localparam int AIF_BIT = 7;
  localparam logic [7:0] PTR_RESET = 8'h80;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [2:0] GROUP_EN_RESET = 3'h1;
  localparam logic [2:0] PINS_WIDTH = 3'h4;
endpackage

// ---- ldp_ptr.sv ----
module ldp_ptr
  import ldp_pkg::*;
(
  input wire logic scl_i,
  input wire logic rst_n_i,
  ldp_ptr_if.unit pb
);
  logic [7:0] ptr_r;
  logic [6:0] idx_nxt;
  logic [6:0] idx;

  assign idx = ptr_r[6:0];
  assign pb.ptr = ptr_r;

  always_comb begin
    idx_nxt = idx;
    if (ptr_r[AIF_BIT]) begin
      case (pb.mode)
        2'b00: idx_nxt = (idx == IDX_LAST) ? IDX_ZERO :
          idx + 7'h01;
        2'b01: idx_nxt = (idx == IDX_PWM_LAST) ? IDX_PWM_FIRST :
          idx + 7'h01;
        2'b10: idx_nxt = (idx == IDX_GAIN_LAST) ? IDX_ZERO :
          idx + 7'h01;
        default: idx_nxt = (idx == IDX_PWM_LAST) ? IDX_GRP_FIRST :
          idx + 7'h01;
      endcase
    end
  end

  // Reset sets the auto-increment flag with index zero.
  always_ff @(posedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_r <= PTR_RESET;
    end else if (pb.load) begin
      ptr_r <= pb.wdata;
    end else if (pb.step) begin
      ptr_r <= {ptr_r[AIF_BIT], idx_nxt};
    end
  end

  a_wrap_full: assert property (@(posedge scl_i)
    disable iff (!rst_n_i)
    pb.step && !pb.load && ptr_r[7] && pb.mode == 2'b00 && idx == 7'h41
    |=> ptr_r[6:0] == 7'h00) else $error("full window wrap wrong");
  a_wrap_pwm: assert property (@(posedge scl_i)
    disable iff (!rst_n_i)
    pb.step && !pb.load && ptr_r[7] && pb.mode == 2'b01 && idx == 7'h19
    |=> ptr_r[6:0] == 7'h0A) else $error("pwm window wrap wrong");
  a_wrap_gain: assert property (@(posedge scl_i)
    disable iff (!rst_n_i)
    pb.step && !pb.load && ptr_r[7] && pb.mode == 2'b10 && idx == 7'h31
    |=> ptr_r[6:0] == 7'h00) else $error("gain window wrap wrong");
  a_wrap_grp: assert property (@(posedge scl_i)
    disable iff (!rst_n_i)
    pb.step && !pb.load && ptr_r[7] && pb.mode == 2'b11 && idx == 7'h19
    |=> ptr_r[6:0] == 7'h08) else $error("group window wrap wrong");
  a_hold_noinc: assert property (@(posedge scl_i)
    disable iff (!rst_n_i)
    pb.step && !pb.load && !ptr_r[7] |=> $stable(ptr_r))
    else $error("index moved without flag");
  a_flag_kept: assert property (@(posedge scl_i)
    disable iff (!rst_n_i)
    pb.step && !pb.load |=> ptr_r[7] == $past(ptr_r[7]))
    else $error("flag changed by increment");
  a_linear_step: assert property (@(posedge scl_i)
    disable iff (!rst_n_i)
    pb.step && !pb.load && ptr_r[7] && idx < 7'h08
    |=> ptr_r[6:0] == $past(idx) + 7'h01)
    else $error("linear count below window wrong");
  c_pwm_wrap: cover property (@(posedge scl_i) disable iff (!rst_n_i)
    pb.step && ptr_r[7] && pb.mode == 2'b01 && idx == 7'h19);
endmodule // ldp_ptr

// ---- ldp_ptr_if.sv ----
interface ldp_ptr_if;
  logic load;
  logic step;
  logic [7:0] wdata;
  logic [1:0] mode;
  logic [7:0] ptr;
  modport ctl (output load, output step, output wdata, output mode,
    input ptr);
  modport unit (input load, input step, input wdata, input mode,
    output ptr);
endinterface
